/* File: dbm_pkg.sv */
// Shared constants, encodings and decoders for the DDR burst and mode-register block
package dbm_pkg;

    // ------------------------------------------------------------
    // Widths of the memory-side pins
    // ------------------------------------------------------------
    localparam int ADDR_W     = 13;
    localparam int DATA_W     = 64;
    localparam int BANK_W     = 2;
    localparam int BANKS      = 4;
    localparam int COL_W      = 11;   // Ten low column bits plus the bit above the precharge flag
    localparam int SYNC_W     = 86;   // All pins that cross into CLOCK through two flops

    // ------------------------------------------------------------
    // Storage kept by this model: bank, one row bit, 16 columns
    // ------------------------------------------------------------
    localparam int MEM_COL_W  = 4;
    localparam int MEM_IDX_W  = 7;
    localparam int MEM_DEPTH  = 128;

    // ------------------------------------------------------------
    // Operating mode register layout and reset value
    // ------------------------------------------------------------
    localparam int MODE_BL_LSB    = 0;
    localparam int MODE_BT_BIT    = 3;
    localparam int MODE_CL_LSB    = 4;
    localparam int MODE_OP_LSB    = 7;
    localparam int DLL_RESET_BIT  = 8;
    localparam int AUTO_PRE_BIT   = 10;
    localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0022;   // Burst of four, sequential, latency two

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    localparam logic [2:0] BL_CODE_2  = 3'h1;
    localparam logic [2:0] BL_CODE_4  = 3'h2;
    localparam logic [2:0] BL_CODE_8  = 3'h3;
    localparam logic [2:0] CL_CODE_2  = 3'h2;
    localparam logic [2:0] CL_CODE_25 = 3'h6;
    localparam logic [2:0] LAT_HALF_2  = 3'h4;   // Two clocks counted in link half periods
    localparam logic [2:0] LAT_HALF_25 = 3'h5;
    localparam logic [1:0] BANK_BASE_MODE = 2'h0;

    // Command codes as {row strobe, column strobe, write enable}, active low
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;

    // ------------------------------------------------------------
    // Burst engine states, Gray coded along idle, read wait, read data, write data
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_RD_WAIT = 2'b01,
        ST_RD_DATA = 2'b11,
        ST_WR_DATA = 2'b10
    } dbm_state_t;

    // Burst length in words, zero for a reserved code
    function automatic logic [3:0] bl_words(input logic [2:0] code);
        unique case (code)
            BL_CODE_2: bl_words = 4'h2;
            BL_CODE_4: bl_words = 4'h4;
            BL_CODE_8: bl_words = 4'h8;
            default:   bl_words = 4'h0;
        endcase
    endfunction : bl_words

    // Read latency in link half periods, zero for a reserved code
    function automatic logic [2:0] lat_halves(input logic [2:0] code);
        unique case (code)
            CL_CODE_2:  lat_halves = LAT_HALF_2;
            CL_CODE_25: lat_halves = LAT_HALF_25;
            default:    lat_halves = 3'h0;
        endcase
    endfunction : lat_halves

endpackage : dbm_pkg

/* File: dbm_burst_order.sv */
// Column order within one burst: wrap inside the aligned block, sequential or interleaved
`timescale 1ns/1ps

module dbm_burst_order
    import dbm_pkg::*;
(
    input  wire logic [COL_W-1:0] start_col,
    input  wire logic [2:0]       bl_code,
    input  wire logic             interleave,
    input  wire logic [2:0]       idx,
    output logic      [COL_W-1:0] col
);

    logic [2:0] mask;
    logic [2:0] offset;

    // ------------------------------------------------------------
    // Low bits move, upper bits pick the block and never change
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (bl_code)
            BL_CODE_2: mask = 3'h1;
            BL_CODE_4: mask = 3'h3;
            BL_CODE_8: mask = 3'h7;
            default:   mask = 3'h0;
        endcase
        offset = interleave ? (start_col[2:0] ^ idx) : 3'(start_col[2:0] + idx);   // [R16] [R17]
        col    = {start_col[COL_W-1:3], (start_col[2:0] & ~mask) | (offset & mask)};   // [R15]
    end

endmodule : dbm_burst_order

/* File: dbm_ddr_device.sv */
// Device-side command decode, bank state, mode register and DDR burst data path
`timescale 1ns/1ps

// Notes on behaviour
// R1: Commands and address are taken once per link clock, at true rising, complement low.
// R2: Write words caught on both strobe edges; read words launched on both clock edges.
// R3: Strobe driven here only during read data; the controller drives it for writes.
// R4: Two words move internally per clock, one word per half cycle at the pins.
// R5: A row must be opened by activate before any read or write to its bank.
// R6: Bank bits and column bits taken with read or write pick bank and start column.
// R7: Burst lengths two, four and eight work with both orderings.
// R8: Auto precharge closes the bank's row by itself when the burst ends.
// R9: Mode set with both bank bits low loads the mode register; it holds until rewritten.
// R10: The DLL reset bit clears itself; other mode fields keep their values.
// R11: Rewriting the mode register leaves stored data untouched.
// R12: Controller loads mode only with banks idle and waits before the next command.
// R13: Mode bits: low three burst length, next burst type, next three latency, rest mode.
// R14: Burst length limits each read and write burst alike.
// R15: A burst wraps inside its aligned block; low column bits give the start.
// R16: One mode bit chooses sequential or interleaved order.
// R17: Column order follows length, type and start column together.
// R18: Read latency is two or two and a half clocks.
// R19: First read word appears at edge n plus latency after the command edge.
// R20: Controller never programs reserved mode codes.
// R21: Four banks keep their own open rows and work concurrently.
// R22: Operating bits zero mean normal; only the DLL bit set means DLL reset.
// R23: Latency code 010 is two, 110 is two and a half, others reserved.
// R24: Length code 001 is two, 010 four, 011 eight, others reserved.
module dbm_ddr_device
    import dbm_pkg::*;
(
    input  wire logic              CLOCK,
    input  wire logic              SYS_RST,
    input  wire logic              DIFF_CLOCK_TRUE,
    input  wire logic              DIFF_CLOCK_COMP,
    input  wire logic              CHIP_SELECT_N,
    input  wire logic              ROW_STROBE_N,
    input  wire logic              COL_STROBE_N,
    input  wire logic              WRITE_EN_N,
    input  wire logic              BANK_SELECT_LOW,
    input  wire logic              BANK_SELECT_HIGH,
    input  wire logic [ADDR_W-1:0] ADDRESS,
    input  wire logic [DATA_W-1:0] DATA_LINES_IN,
    output logic      [DATA_W-1:0] DATA_LINES_OUT,
    output logic                   DATA_LINES_OE_N,
    input  wire logic              DATA_STROBE_IN,
    output logic                   DATA_STROBE_OUT,
    output logic                   DATA_STROBE_OE_N
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic              ck_t;
    logic              ck_c;
    logic              cs_n;
    logic [2:0]        cmd;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic              dqs_s;
    logic [DATA_W-1:0] dq_s;

    // Every pin passes two flops; only the second stage is read
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            sync_a <= '0;
            sync_b <= '0;
        end
        else
        begin
            sync_a <= {DIFF_CLOCK_TRUE, DIFF_CLOCK_COMP, CHIP_SELECT_N, ROW_STROBE_N, COL_STROBE_N,
                       WRITE_EN_N, BANK_SELECT_HIGH, BANK_SELECT_LOW, ADDRESS, DATA_STROBE_IN,
                       DATA_LINES_IN};
            sync_b <= sync_a;
        end
    end

    assign {ck_t, ck_c, cs_n, cmd, ba, addr, dqs_s, dq_s} = sync_b;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dbm_state_t        st,          next_st;
    logic [ADDR_W-1:0] mode,        next_mode;
    logic [BANKS-1:0]  bank_open,   next_bank_open;
    logic [ADDR_W-1:0] bank_row     [BANKS];
    logic [ADDR_W-1:0] next_bank_row[BANKS];
    logic              ck_prev,     next_ck_prev;
    logic              dqs_prev,    next_dqs_prev;
    logic [BANK_W-1:0] burst_bank,  next_burst_bank;
    logic [COL_W-1:0]  burst_col,   next_burst_col;
    logic              burst_ap,    next_burst_ap;
    logic [2:0]        word_idx,    next_word_idx;
    logic [2:0]        half_cnt,    next_half_cnt;
    logic [DATA_W-1:0] dq_hold,     next_dq_hold;
    logic [DATA_W-1:0] dq_out,      next_dq_out;
    logic              dq_oe_n,     next_dq_oe_n;
    logic              dqs_out,     next_dqs_out;
    logic              dqs_oe_n,    next_dqs_oe_n;

    logic [DATA_W-1:0] mem [MEM_DEPTH];

    // ------------------------------------------------------------
    // Edge detection and command decode
    // ------------------------------------------------------------
    logic              link_rise;
    logic              link_fall;
    logic              link_edge;
    logic              cmd_valid;
    logic              strobe_edge;
    logic [3:0]        bl_len;
    logic [2:0]        lat_half;
    logic [COL_W-1:0]  col_in;
    logic              is_read;
    logic              is_write;
    logic              entering_rd;
    logic              last_word;
    logic              rd_step;
    logic              rd_end;
    logic              rd_term;
    logic              wr_fire;
    logic [2:0]        base_idx;
    logic [COL_W-1:0]  col_a;
    logic [COL_W-1:0]  col_b;
    logic [MEM_IDX_W-1:0] idx_a;
    logic [MEM_IDX_W-1:0] idx_b;
    logic [BANK_W-1:0] row_sel;

    assign link_rise   = ck_t & ~ck_prev & ~ck_c;   // [R1]
    assign link_fall   = ~ck_t & ck_prev;
    assign link_edge   = link_rise | link_fall;
    assign cmd_valid   = link_rise & ~cs_n;   // [R1]
    assign strobe_edge = dqs_s ^ dqs_prev;
    assign bl_len      = bl_words(mode[MODE_BL_LSB +: 3]);   // [R24] [R7]
    assign lat_half    = lat_halves(mode[MODE_CL_LSB +: 3]);   // [R23]
    assign col_in      = {addr[11], addr[9:0]};   // [R6]

    // Column access only into an open row; a reserved length code leaves either unanswered, a reserved latency code only a read
    assign is_read  = cmd_valid && cmd == CMD_RD && st == ST_IDLE && bank_open[ba]
                      && bl_len != 4'h0 && lat_half != 3'h0;   // [R5] [R18]
    assign is_write = cmd_valid && cmd == CMD_WR && st == ST_IDLE && bank_open[ba]
                      && bl_len != 4'h0;   // [R5]

    // Burst sequencing terms
    assign last_word   = {1'b0, word_idx} == 4'(bl_len - 4'h1);   // [R14]
    assign entering_rd = st == ST_RD_WAIT && link_edge && half_cnt == 3'(lat_half - 3'h1);   // [R19]
    assign rd_term     = st == ST_RD_DATA && cmd_valid && cmd == CMD_BST && !burst_ap;
    assign rd_end      = st == ST_RD_DATA && link_edge && (last_word || rd_term);
    assign rd_step     = st == ST_RD_DATA && link_edge && !last_word && !rd_term;
    assign wr_fire     = st == ST_WR_DATA && strobe_edge && word_idx[0];   // [R4]

    // Pair of columns for the current double-width internal access
    assign base_idx = (st == ST_WR_DATA) ? {word_idx[2:1], 1'b0}
                    : (entering_rd ? 3'h0 : 3'(word_idx + 3'h1));

    dbm_burst_order u_order_a (
        .start_col  (burst_col),
        .bl_code    (mode[MODE_BL_LSB +: 3]),
        .interleave (mode[MODE_BT_BIT]),
        .idx        (base_idx),
        .col        (col_a)
    );

    dbm_burst_order u_order_b (
        .start_col  (burst_col),
        .bl_code    (mode[MODE_BL_LSB +: 3]),
        .interleave (mode[MODE_BT_BIT]),
        .idx        (3'(base_idx + 3'h1)),
        .col        (col_b)
    );

    // Each bank indexes storage with its own open row
    assign row_sel = burst_bank;
    assign idx_a   = {burst_bank, bank_row[row_sel][0], col_a[MEM_COL_W-1:0]};   // [R21]
    assign idx_b   = {burst_bank, bank_row[row_sel][0], col_b[MEM_COL_W-1:0]};

    // ------------------------------------------------------------
    // Storage: the second word of a pair arrives, both words land
    // ------------------------------------------------------------
    // Mode writes never reach this array, so data survives reprogramming
    always_ff @(posedge CLOCK)
    begin
        if (wr_fire)
        begin
            mem[idx_a] <= dq_hold;   // [R4] [R11]
            mem[idx_b] <= dq_s;
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_st         = st;
        next_mode       = mode;
        next_bank_open  = bank_open;
        next_bank_row   = bank_row;
        next_ck_prev    = ck_t;
        next_dqs_prev   = dqs_s;
        next_burst_bank = burst_bank;
        next_burst_col  = burst_col;
        next_burst_ap   = burst_ap;
        next_word_idx   = word_idx;
        next_half_cnt   = half_cnt;
        next_dq_hold    = dq_hold;
        next_dq_out     = dq_out;
        next_dq_oe_n    = dq_oe_n;
        next_dqs_out    = dqs_out;
        next_dqs_oe_n   = dqs_oe_n;

        // Self-clearing DLL reset; a later set command may raise it again
        if (mode[DLL_RESET_BIT])
            next_mode[DLL_RESET_BIT] = 1'b0;   // [R10]

        // Bank and mode commands act in any burst state, so banks overlap
        if (cmd_valid)
        begin
            unique case (cmd)
                CMD_ACT:
                begin
                    next_bank_open[ba] = 1'b1;   // [R5] [R21]
                    next_bank_row[ba]  = addr;
                end
                CMD_PRE:
                begin
                    if (addr[AUTO_PRE_BIT])
                        next_bank_open = '0;
                    else
                        next_bank_open[ba] = 1'b0;
                end
                CMD_MRS:
                begin
                    // Extended register is outside this block; it is ignored here
                    if (ba == BANK_BASE_MODE)
                        next_mode = addr;   // [R9] [R13] [R22]
                end
                default:
                begin
                end
            endcase
        end

        unique case (st)
            ST_IDLE:
            begin
                if (is_read || is_write)
                begin
                    next_burst_bank = ba;   // [R6]
                    next_burst_col  = col_in;
                    next_burst_ap   = addr[AUTO_PRE_BIT];
                    next_word_idx   = 3'h0;
                    next_half_cnt   = 3'h0;
                    next_st         = is_read ? ST_RD_WAIT : ST_WR_DATA;
                end
            end
            ST_RD_WAIT:
            begin
                if (link_edge)
                    next_half_cnt = 3'(half_cnt + 3'h1);
                if (entering_rd)
                begin
                    next_st       = ST_RD_DATA;
                    next_dq_out   = mem[idx_a];   // [R4] [R19]
                    next_dq_hold  = mem[idx_b];
                    next_dq_oe_n  = 1'b0;
                    next_dqs_oe_n = 1'b0;   // [R3]
                    next_dqs_out  = 1'b1;   // [R2]
                end
            end
            ST_RD_DATA:
            begin
                if (rd_step)
                begin
                    next_word_idx = 3'(word_idx + 3'h1);
                    next_dqs_out  = ~dqs_out;   // [R2]
                    // Even words fetch a fresh pair, odd words drain the held half
                    if (word_idx[0])
                    begin
                        next_dq_out  = mem[idx_a];   // [R4]
                        next_dq_hold = mem[idx_b];
                    end
                    else
                        next_dq_out = dq_hold;
                end
                else if (rd_end)
                begin
                    next_st       = ST_IDLE;
                    next_dq_oe_n  = 1'b1;   // [R3]
                    next_dqs_oe_n = 1'b1;
                    next_dqs_out  = 1'b0;
                    if (burst_ap)
                        next_bank_open[burst_bank] = 1'b0;   // [R8]
                end
            end
            ST_WR_DATA:
            begin
                if (strobe_edge)
                begin
                    // Both strobe edges carry a word; the first of a pair waits here
                    if (!word_idx[0])
                        next_dq_hold = dq_s;   // [R2]
                    if (last_word)
                    begin
                        next_st = ST_IDLE;   // [R14]
                        if (burst_ap)
                            next_bank_open[burst_bank] = 1'b0;   // [R8]
                    end
                    else
                        next_word_idx = 3'(word_idx + 3'h1);
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            st         <= ST_IDLE;
            mode       <= MODE_RESET;
            bank_open  <= '0;
            bank_row   <= '{default: '0};
            ck_prev    <= 1'b0;
            dqs_prev   <= 1'b0;
            burst_bank <= '0;
            burst_col  <= '0;
            burst_ap   <= 1'b0;
            word_idx   <= 3'h0;
            half_cnt   <= 3'h0;
            dq_hold    <= '0;
            dq_out     <= '0;
            dq_oe_n    <= 1'b1;
            dqs_out    <= 1'b0;
            dqs_oe_n   <= 1'b1;
        end
        else
        begin
            st         <= next_st;
            mode       <= next_mode;
            bank_open  <= next_bank_open;
            bank_row   <= next_bank_row;
            ck_prev    <= next_ck_prev;
            dqs_prev   <= next_dqs_prev;
            burst_bank <= next_burst_bank;
            burst_col  <= next_burst_col;
            burst_ap   <= next_burst_ap;
            word_idx   <= next_word_idx;
            half_cnt   <= next_half_cnt;
            dq_hold    <= next_dq_hold;
            dq_out     <= next_dq_out;
            dq_oe_n    <= next_dq_oe_n;
            dqs_out    <= next_dqs_out;
            dqs_oe_n   <= next_dqs_oe_n;
        end
    end

    assign DATA_LINES_OUT   = dq_out;
    assign DATA_LINES_OE_N  = dq_oe_n;
    assign DATA_STROBE_OUT  = dqs_out;
    assign DATA_STROBE_OE_N = dqs_oe_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    mode_on_rise_a: assert property ( // [R1]
        ($changed(mode) && !$past(mode[DLL_RESET_BIT])) |-> $past(link_rise && !cs_n))
        else $error("mode changed without a registered command");

    mode_write_a: assert property ( // [R9]
        (cmd_valid && cmd == CMD_MRS && ba == BANK_BASE_MODE)
        |=> (mode[7:0] == $past(addr[7:0])) && (mode[12:9] == $past(addr[12:9])))
        else $error("mode register did not take the set value");

    dll_clear_a: assert property ( // [R10]
        mode[DLL_RESET_BIT] |=> !mode[DLL_RESET_BIT] && $stable(mode[7:0]))
        else $error("dll reset bit did not clear alone");

    read_launch_a: assert property ( // [R18]
        is_read |=> (st == ST_RD_WAIT) && (half_cnt == 3'h0) && dq_oe_n)
        else $error("read command not taken into latency wait");

    latency_a: assert property ( // [R19]
        entering_rd |=> (st == ST_RD_DATA) && !DATA_LINES_OE_N && DATA_STROBE_OUT && (word_idx == 3'h0))
        else $error("first read word not launched at latency edge");

    strobe_toggle_a: assert property ( // [R2]
        rd_step |=> $changed(DATA_STROBE_OUT) && (DATA_STROBE_OUT == !word_idx[0]))
        else $error("read strobe did not follow the data word");

    drive_only_read_a: assert property ( // [R3]
        (!DATA_STROBE_OE_N || !DATA_LINES_OE_N) |-> (st == ST_RD_DATA))
        else $error("pins driven outside read data");

    open_row_a: assert property ( // [R5]
        (cmd_valid && (cmd == CMD_RD || cmd == CMD_WR) && st == ST_IDLE && !bank_open[ba])
        |=> st == ST_IDLE)
        else $error("column access accepted into a closed bank");

    auto_pre_a: assert property ( // [R8]
        (st != ST_IDLE && next_st == ST_IDLE && burst_ap) |=> !bank_open[$past(burst_bank)])
        else $error("auto precharge left the row open");

    burst_len_a: assert property ( // [R14]
        (st == ST_RD_DATA || st == ST_WR_DATA) |-> ({1'b0, word_idx} < bl_len))
        else $error("burst ran past its programmed length");

endmodule : dbm_ddr_device

/* File: dbm_host.sv */
// Controller-side model: link clock, command pins and write strobe
`timescale 1ns/1ps
module dbm_host
    import dbm_pkg::*;
(
    output logic              ck,
    output logic              cs_n,
    output logic [2:0]        cmd,
    output logic [BANK_W-1:0] ba,
    output logic [ADDR_W-1:0] ad,
    output logic [DATA_W-1:0] dq,
    output logic              dqs
);
    // ----
    // Link clock, low through reset, then free running
    // ----
    initial
    begin
        {ck, dqs, dq} = '0;
        {cs_n, cmd, ba, ad} = '1;
        // Odd start keeps link edges off the system clock's rising edge
        #202;
        forever #62.5 ck = ~ck;
    end

    // Pins held mid low phase to mid high phase around the rise
    task automatic send(input logic [2:0] c, input logic [1:0] b, input logic [ADDR_W-1:0] a);
        @(negedge ck);
        #31;
        {cs_n, cmd, ba, ad} = {1'b0, c, b, a};
        @(posedge ck);
        #31;
        {cs_n, cmd, ba, ad} = '1;
    endtask : send

    // Word centred on its strobe edge; bus scrambled once released
    task automatic burst(input logic [DATA_W-1:0] base, input int n);
        for (int k = 0; k < n; k++)
        begin
            dq = base + DATA_W'(k);
            #40;
            dqs = ~dqs;
            #40;
        end
        dq = ~dq;
    endtask : burst
endmodule : dbm_host

/* File: ddr_burst_mode_register_access_test.sv */
// Self-checking bench for the DDR burst and mode-register device
`timescale 1ns/1ps
module ddr_burst_mode_register_access_test
    import dbm_pkg::*;
;
    localparam logic [DATA_W-1:0] BASE = 64'hA5C3_0000_0000_0000;
    logic              CLOCK, SYS_RST, ck, cs_n, dqs, s_out, s_oe_n, d_oe_n;
    logic [2:0]        cmd;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] ad;
    logic [DATA_W-1:0] dq, d_out;
    int                error_cnt, cmp_count;

    always #5 CLOCK = ~CLOCK;

    dbm_host i_dbm_host (.ck(ck), .cs_n(cs_n), .cmd(cmd), .ba(ba), .ad(ad), .dq(dq), .dqs(dqs));

    // Shared lines resolved from both enables
    dbm_ddr_device i_dbm_ddr_device (
        .CLOCK(CLOCK), .SYS_RST(SYS_RST), .DIFF_CLOCK_TRUE(ck), .DIFF_CLOCK_COMP(~ck),
        .CHIP_SELECT_N(cs_n), .ROW_STROBE_N(cmd[2]), .COL_STROBE_N(cmd[1]), .WRITE_EN_N(cmd[0]),
        .BANK_SELECT_LOW(ba[0]), .BANK_SELECT_HIGH(ba[1]), .ADDRESS(ad),
        .DATA_LINES_IN(d_oe_n ? dq : d_out), .DATA_LINES_OUT(d_out), .DATA_LINES_OE_N(d_oe_n),
        .DATA_STROBE_IN(s_oe_n ? dqs : s_out), .DATA_STROBE_OUT(s_out), .DATA_STROBE_OE_N(s_oe_n));

    // ----
    // Checks
    // ----
    task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Fixed window, so a refused read shows as zero words
    task automatic rd(input logic [1:0] b, input logic [ADDR_W-1:0] a, input int n, input logic il,
                      input logic term = 1'b0);
        logic [3:0] c;
        logic       last;
        int         got;
        last = 1'b0;
        got = 0;
        i_dbm_host.send(CMD_RD, b, a);
        // Two idle commands, then a terminate at the third link rise after the read
        fork
            if (term)
            begin
                repeat (2) i_dbm_host.send(3'h7, 2'h0, 13'h0000);
                i_dbm_host.send(CMD_BST, 2'h0, 13'h0000);
            end
        join_none
        // Every driven word is counted, so an extra or unwanted burst shows
        for (int i = 0; i < 400; i++)
        begin
            @(negedge CLOCK);
            if (d_oe_n === 1'b0 && s_oe_n === 1'b0 && s_out !== last)
            begin
                c = il ? (a[3:0] ^ got[3:0]) : ((a[3:0] & 4'(~(n - 1))) | 4'((a[3:0] + got) % n));
                chk("read word", BASE + DATA_W'(c), d_out);
                last = s_out;
                got++;
            end
        end
        chk("read count", DATA_W'(n), DATA_W'(got));
    endtask : rd

    task automatic sc_seq;
        i_dbm_host.send(CMD_MRS, BANK_BASE_MODE, {6'h00, CL_CODE_2, 1'b0, BL_CODE_8});
        i_dbm_host.send(CMD_ACT, 2'h1, 13'h0000);
        i_dbm_host.send(CMD_WR, 2'h1, 13'h0000);
        i_dbm_host.burst(BASE, 8);
        rd(2'h1, 13'h0000, 8, 1'b0);
    endtask : sc_seq

    // Every length with both orders; last mode also asks a DLL reset
    task automatic sc_wrap;
        for (int t = 0; t < 6; t++)
        begin
            i_dbm_host.send(CMD_PRE, 2'h0, 13'h0400);
            i_dbm_host.send(CMD_MRS, BANK_BASE_MODE,
                {4'h0, t == 5, 1'b0, t > 2 ? CL_CODE_25 : CL_CODE_2, t > 2, 3'(t % 3 + 1)});
            i_dbm_host.send(CMD_ACT, 2'h1, 13'h0000);
            rd(2'h1, 13'h0005, 2 << (t % 3), t > 2);
        end
    endtask : sc_wrap

    // Closed bank refused; auto precharge closes the row
    task automatic sc_close;
        rd(2'h2, 13'h0000, 0, 1'b0);
        i_dbm_host.send(CMD_ACT, 2'h3, 13'h0000);
        // Latency two and a half: terminate lands on the second word's edge
        rd(2'h1, 13'h0000, 1, 1'b1, 1'b1);
        rd(2'h1, 13'h0400, 8, 1'b1);
        rd(2'h1, 13'h0000, 0, 1'b0);
    endtask : sc_close

    task automatic give_verdict;
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        CLOCK = 1'b0;
        SYS_RST = 1'b1;
        error_cnt = 0;
        cmp_count = 0;
        repeat (10) @(negedge CLOCK);
        SYS_RST = 1'b0;
        sc_seq();
        sc_wrap();
        sc_close();
        give_verdict();
    end
endmodule : ddr_burst_mode_register_access_test
